/* File: hw/bior_pkg.sv */
// ==========================================================
// register map
package bior_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int ROUTE_LEN = 56;
  localparam int NUM_CNT = 3;
  localparam int PORT_W = 4;

  localparam logic [4:0] OFS_DIO = 5'h00;
  localparam logic [4:0] OFS_CONFIG_REG_ONE = 5'h02;
  localparam logic [4:0] OFS_CONFIG_REG_THREE = 5'h04;
  localparam logic [4:0] OFS_RT_SHIFT = 5'h06;
  localparam logic [4:0] OFS_RT_STROBE = 5'h07;
  localparam logic [4:0] OFS_CNT_CMD = 5'h09;
  localparam logic [4:0] OFS_CNT_STAT1 = 5'h10;
  localparam logic [4:0] OFS_CNT_STAT2 = 5'h11;
  localparam logic [4:0] OFS_CNT_STAT3 = 5'h12;

  // ==========================================================
  // field positions
  localparam int CONFIG_REG_ONE_PAGE_BIT = 0;
  localparam int CONFIG_REG_THREE_PORT_A_EN_BIT = 0;
  localparam int CONFIG_REG_THREE_PORT_B_EN_BIT = 1;
  localparam int ROUTE_BIT_POS = 0;
  localparam int PORT_A_LSB = 0;
  localparam int PORT_B_LSB = 4;

  // ==========================================================
  // reset values and command codes
  localparam logic [7:0] CONFIG_REG_ONE_RST = 8'h00;
  localparam logic [7:0] CONFIG_REG_THREE_RST = 8'h00;
  localparam logic [7:0] DOUT_RST = 8'h00;
  localparam logic [ROUTE_LEN-1:0] ROUTE_RST = 56'h0;
  localparam logic [1:0] CMD_SEL_READBACK = 2'h3;
  localparam logic [1:0] CMD_ACC_LATCH = 2'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] sel;
    logic [1:0] access;
    logic [2:0] mode;
    logic bcd;
  } bior_cmd_type;

  typedef struct packed {
    logic out_level;
    logic null_count;
    logic [1:0] access;
    logic [2:0] mode;
    logic bcd;
  } bior_status_type;

  localparam bior_status_type STATUS_RST = 8'h00;
endpackage

/* File: hw/bior_route_chain.sv */
`timescale 1ns/1ps
// ==========================================================
// routing shift chain and active switch control
module bior_route_chain (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic shift_wr_i,
  input wire logic serial_bit_i,
  input wire logic strobe_wr_i,
  output logic [bior_pkg::ROUTE_LEN-1:0] switch_ctrl_o
);
  logic [bior_pkg::ROUTE_LEN-1:0] chain_r;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      chain_r <= bior_pkg::ROUTE_RST;
    end else if (shift_wr_i) begin
      chain_r <= {chain_r[bior_pkg::ROUTE_LEN-2:0], serial_bit_i};
    end
  end

  // whole pattern moves at once so the switch never sees a half load
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      switch_ctrl_o <= bior_pkg::ROUTE_RST;
    end else if (strobe_wr_i) begin
      switch_ctrl_o <= chain_r;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  a_chain_shift_in: assert property (shift_wr_i |=> chain_r[0] == $past(serial_bit_i)
    && chain_r[bior_pkg::ROUTE_LEN-1:1] == $past(chain_r[bior_pkg::ROUTE_LEN-2:0]))
    else $error("routing chain did not shift");
  a_strobe_copy: assert property (strobe_wr_i |=> switch_ctrl_o == $past(chain_r))
    else $error("strobe did not load switch control");
  a_ctrl_hold: assert property (!strobe_wr_i |=> $stable(switch_ctrl_o))
    else $error("switch control changed without strobe");
  c_strobe_load: cover property (shift_wr_i ##[1:60] strobe_wr_i);
endmodule

/* File: hw/bior_cnt_status.sv */
`timescale 1ns/1ps
// ==========================================================
// counter programming copy and status latch
module bior_cnt_status (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic cmd_wr_i,
  input wire bior_pkg::bior_cmd_type cmd_i,
  input wire logic [bior_pkg::NUM_CNT-1:0] out_level_i,
  input wire logic [bior_pkg::NUM_CNT-1:0] null_count_i,
  input wire logic [bior_pkg::NUM_CNT-1:0] take_i,
  output bior_pkg::bior_status_type [bior_pkg::NUM_CNT-1:0] status_o
);
  bior_pkg::bior_status_type [bior_pkg::NUM_CNT-1:0] prog_r;
  logic [bior_pkg::NUM_CNT-1:0] held_r;
  logic [bior_pkg::NUM_CNT-1:0] capture;
  logic is_rb;

  assign is_rb = cmd_wr_i && cmd_i.sel == bior_pkg::CMD_SEL_READBACK;

  // counter mask sits in the mode field of a read-back word
  always_comb begin
    for (int i = 0; i < bior_pkg::NUM_CNT; i++) begin
      capture[i] = is_rb && !cmd_i.access[0] && cmd_i.mode[i] && (!held_r[i] || take_i[i]);
    end
  end

  // latch commands leave the programmed copy untouched
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prog_r <= {bior_pkg::NUM_CNT{bior_pkg::STATUS_RST}};
    end else if (cmd_wr_i && cmd_i.sel != bior_pkg::CMD_SEL_READBACK
                 && cmd_i.access != bior_pkg::CMD_ACC_LATCH) begin
      prog_r[cmd_i.sel].access <= cmd_i.access;
      prog_r[cmd_i.sel].mode <= cmd_i.mode;
      prog_r[cmd_i.sel].bcd <= cmd_i.bcd;
    end
  end

  // first latch wins until read; a new latch in the read cycle is kept
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      held_r <= '0;
      status_o <= {bior_pkg::NUM_CNT{bior_pkg::STATUS_RST}};
    end else begin
      for (int i = 0; i < bior_pkg::NUM_CNT; i++) begin
        if (capture[i]) begin
          held_r[i] <= 1'b1;
          status_o[i] <= {out_level_i[i], null_count_i[i], prog_r[i].access,
                          prog_r[i].mode, prog_r[i].bcd};
        end else if (take_i[i]) begin
          held_r[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  a_stat_capture: assert property (capture[0] |=> held_r[0]
    && status_o[0].out_level == $past(out_level_i[0])
    && status_o[0].null_count == $past(null_count_i[0]))
    else $error("status of counter 1 not captured");
  a_stat_fields: assert property (capture[2] |=> status_o[2].access == $past(prog_r[2].access)
    && status_o[2].mode == $past(prog_r[2].mode) && status_o[2].bcd == $past(prog_r[2].bcd))
    else $error("status fields of counter 3 wrong");
  a_stat_first_wins: assert property (held_r[1] && !take_i[1] |=> $stable(status_o[1]))
    else $error("held status overwritten");
  c_readback: cover property (is_rb && !cmd_i.access[0] && cmd_i.mode == 3'h7);
endmodule

/* File: hw/bior_board_io_regs.sv */
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - a read-back word with its status-request bit low latches the status of each chosen counter not already holding an unread status.
// - the status byte holds output level, null flag, access copy, mode copy and decimal flag.
// - status bits 5 and 4 copy the access select last programmed for that counter.
// - each write to the shift register moves data bit 0 into the 56-bit chain, other bits unused.
// - any write to the strobe register copies the chain into the switch control, data unused.
// - shift at 06 and strobe at 07 decode only while the page bit is set.
// - reading the input register gives port B levels in bits 7-4 and port A in bits 3-0.
// - writing the output register stores bits 7-4 for port B and bits 3-0 for port A.
// - port B lines are driven only while the port B drive enable is set.
// - port A lines are driven only while the port A drive enable is set.
// - with the page bit clear, offset 00 is the input register on reads, output on writes.
module bior_board_io_regs (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [bior_pkg::ADDR_W-1:0] addr_i,
  input wire logic [bior_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [bior_pkg::DATA_W-1:0] rdata_o,
  input wire logic [bior_pkg::PORT_W-1:0] port_a_lines_i,
  output logic [bior_pkg::PORT_W-1:0] port_a_lines_o,
  output logic [bior_pkg::PORT_W-1:0] port_a_lines_oe_o,
  input wire logic [bior_pkg::PORT_W-1:0] port_b_lines_i,
  output logic [bior_pkg::PORT_W-1:0] port_b_lines_o,
  output logic [bior_pkg::PORT_W-1:0] port_b_lines_oe_o,
  input wire logic [bior_pkg::NUM_CNT-1:0] cnt_out_level_i,
  input wire logic [bior_pkg::NUM_CNT-1:0] cnt_null_count_i,
  output logic [bior_pkg::ROUTE_LEN-1:0] switch_ctrl_o
);
  // ==========================================================
  // declarations
  logic [7:0] config_reg_one_r;
  logic [7:0] config_reg_three_r;
  logic [2*bior_pkg::PORT_W-1:0] lines_meta_r;
  logic [2*bior_pkg::PORT_W-1:0] lines_sync_r;
  logic [bior_pkg::NUM_CNT-1:0] cnt_meta_r;
  logic [bior_pkg::NUM_CNT-1:0] cnt_sync_r;
  logic [bior_pkg::NUM_CNT-1:0] stat_take;
  logic [bior_pkg::DATA_W-1:0] rdata_nxt;
  bior_pkg::bior_status_type [bior_pkg::NUM_CNT-1:0] cnt_status;
  logic register_page_select;
  logic port_a_drive_enable;
  logic port_b_drive_enable;
  logic dio_wr;
  logic dio_rd;
  logic shift_wr;
  logic strobe_wr;
  logic cmd_wr;

  // ==========================================================
  // address decode
  function automatic logic hit(input logic [bior_pkg::ADDR_W-1:0] addr,
                               input logic [bior_pkg::ADDR_W-1:0] ofs,
                               input logic strobe);
    hit = strobe && (addr == ofs);
  endfunction

  assign register_page_select = config_reg_one_r[bior_pkg::CONFIG_REG_ONE_PAGE_BIT];
  assign port_a_drive_enable = config_reg_three_r[bior_pkg::CONFIG_REG_THREE_PORT_A_EN_BIT];
  assign port_b_drive_enable = config_reg_three_r[bior_pkg::CONFIG_REG_THREE_PORT_B_EN_BIT];

  assign dio_wr = hit(addr_i, bior_pkg::OFS_DIO, wr_i) && !register_page_select;
  assign dio_rd = hit(addr_i, bior_pkg::OFS_DIO, rd_i) && !register_page_select;
  assign shift_wr = hit(addr_i, bior_pkg::OFS_RT_SHIFT, wr_i) && register_page_select;
  assign strobe_wr = hit(addr_i, bior_pkg::OFS_RT_STROBE, wr_i) && register_page_select;
  assign cmd_wr = hit(addr_i, bior_pkg::OFS_CNT_CMD, wr_i);

  assign stat_take[0] = hit(addr_i, bior_pkg::OFS_CNT_STAT1, rd_i);
  assign stat_take[1] = hit(addr_i, bior_pkg::OFS_CNT_STAT2, rd_i);
  assign stat_take[2] = hit(addr_i, bior_pkg::OFS_CNT_STAT3, rd_i);

  // ==========================================================
  // pin synchronisers
  // lines change at any time relative to the bus clock
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      lines_meta_r <= '0;
      lines_sync_r <= '0;
    end else begin
      lines_meta_r <= {port_b_lines_i, port_a_lines_i};
      lines_sync_r <= lines_meta_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_meta_r <= '0;
      cnt_sync_r <= '0;
    end else begin
      cnt_meta_r <= cnt_out_level_i;
      cnt_sync_r <= cnt_meta_r;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      config_reg_one_r <= bior_pkg::CONFIG_REG_ONE_RST;
    end else if (hit(addr_i, bior_pkg::OFS_CONFIG_REG_ONE, wr_i)) begin
      config_reg_one_r <= wdata_i[7:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      config_reg_three_r <= bior_pkg::CONFIG_REG_THREE_RST;
    end else if (hit(addr_i, bior_pkg::OFS_CONFIG_REG_THREE, wr_i)) begin
      config_reg_three_r <= wdata_i[7:0];
    end
  end

  // ==========================================================
  // digital output latch and drivers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      port_a_lines_o <= bior_pkg::DOUT_RST[bior_pkg::PORT_A_LSB +: bior_pkg::PORT_W];
      port_b_lines_o <= bior_pkg::DOUT_RST[bior_pkg::PORT_B_LSB +: bior_pkg::PORT_W];
    end else if (dio_wr) begin
      port_a_lines_o <= wdata_i[bior_pkg::PORT_A_LSB +: bior_pkg::PORT_W];
      port_b_lines_o <= wdata_i[bior_pkg::PORT_B_LSB +: bior_pkg::PORT_W];
    end
  end

  // enables follow the config register so they switch with the write
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      port_a_lines_oe_o <= '0;
      port_b_lines_oe_o <= '0;
    end else if (hit(addr_i, bior_pkg::OFS_CONFIG_REG_THREE, wr_i)) begin
      port_a_lines_oe_o <= {bior_pkg::PORT_W{wdata_i[bior_pkg::CONFIG_REG_THREE_PORT_A_EN_BIT]}};
      port_b_lines_oe_o <= {bior_pkg::PORT_W{wdata_i[bior_pkg::CONFIG_REG_THREE_PORT_B_EN_BIT]}};
    end
  end

  // ==========================================================
  // routing switch
  // chain length and strobe order are left to software
  bior_route_chain u_route (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .shift_wr_i(shift_wr),
    .serial_bit_i(wdata_i[bior_pkg::ROUTE_BIT_POS]),
    .strobe_wr_i(strobe_wr),
    .switch_ctrl_o(switch_ctrl_o)
  );

  // ==========================================================
  // counter status
  bior_cnt_status u_cnt (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .cmd_wr_i(cmd_wr),
    .cmd_i(bior_pkg::bior_cmd_type'(wdata_i[7:0])),
    .out_level_i(cnt_sync_r),
    .null_count_i(cnt_null_count_i),
    .take_i(stat_take),
    .status_o(cnt_status)
  );

  // ==========================================================
  // read data
  // unmapped and write-only offsets read as zero
  always_comb begin
    rdata_nxt = '0;
    if (dio_rd) begin
      rdata_nxt = {8'h00, lines_sync_r};
    end else if (hit(addr_i, bior_pkg::OFS_CONFIG_REG_ONE, rd_i)) begin
      rdata_nxt = {8'h00, config_reg_one_r};
    end else if (hit(addr_i, bior_pkg::OFS_CONFIG_REG_THREE, rd_i)) begin
      rdata_nxt = {8'h00, config_reg_three_r};
    end else if (stat_take[0]) begin
      rdata_nxt = {8'h00, cnt_status[0]};
    end else if (stat_take[1]) begin
      rdata_nxt = {8'h00, cnt_status[1]};
    end else if (stat_take[2]) begin
      rdata_nxt = {8'h00, cnt_status[2]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  a_dout_store: assert property (dio_wr |=> port_a_lines_o == $past(wdata_i[3:0])
    && port_b_lines_o == $past(wdata_i[7:4]))
    else $error("output latch not stored");
  a_dout_paged: assert property (wr_i && addr_i == bior_pkg::OFS_DIO && register_page_select
    |=> $stable(port_a_lines_o) && $stable(port_b_lines_o))
    else $error("output latch written with page set");
  a_din_read: assert property (dio_rd |=> rdata_o == {8'h00, $past(lines_sync_r)})
    else $error("input register read wrong");
  a_din_two_flop: assert property (##3 dio_rd
    |=> rdata_o[3:0] == $past(port_a_lines_i, 3))
    else $error("port A input sync depth wrong");
  a_port_a_drive: assert property (port_a_lines_oe_o != '0 |-> port_a_drive_enable)
    else $error("port A driven without enable");
  a_port_b_drive: assert property (!port_b_drive_enable |-> port_b_lines_oe_o == '0)
    else $error("port B driven without enable");
  a_port_release: assert property (hit(addr_i, bior_pkg::OFS_CONFIG_REG_THREE, wr_i)
    && !wdata_i[bior_pkg::CONFIG_REG_THREE_PORT_A_EN_BIT] |=> port_a_lines_oe_o == '0)
    else $error("port A not released");
  a_route_paged: assert property (wr_i && addr_i == bior_pkg::OFS_RT_STROBE
    && !register_page_select |=> $stable(switch_ctrl_o))
    else $error("strobe decoded with page clear");
  a_stat_read: assert property (stat_take[1] |=> rdata_o[7:0] == $past(cnt_status[1]))
    else $error("status byte read wrong");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data stood past its cycle");

  c_drive_a: cover property (dio_wr ##1 port_a_drive_enable);
  c_din_read: cover property (dio_rd ##1 rdata_o != '0);
  c_stat_read: cover property (cmd_wr ##[1:4] stat_take[0]);
endmodule

/* File: dv/bior_line_model.sv */
`timescale 1ns/1ps
// ==========================================================
// far side of one digital port: outside drivers, no pull resistor
module bior_line_model (
  input wire logic clock_i,
  input wire logic [bior_pkg::PORT_W-1:0] dev_i,
  input wire logic [bior_pkg::PORT_W-1:0] dev_oe_i,
  input wire logic [bior_pkg::PORT_W-1:0] ext_i,
  input wire logic [bior_pkg::PORT_W-1:0] ext_en_i,
  output logic [bior_pkg::PORT_W-1:0] lines_o
);
  // floating lines wander each cycle so a stale level never reads as a match
  logic [bior_pkg::PORT_W-1:0] float_r = 4'h5;

  always_ff @(posedge clock_i) begin
    float_r <= ~float_r;
  end

  // two drivers on one line give an unknown, never a quiet winner
  always_comb begin
    for (int k = 0; k < bior_pkg::PORT_W; k++) begin
      if (dev_oe_i[k] && ext_en_i[k]) begin
        lines_o[k] = 1'bx;
      end else if (dev_oe_i[k]) begin
        lines_o[k] = dev_i[k];
      end else if (ext_en_i[k]) begin
        lines_o[k] = ext_i[k];
      end else begin
        lines_o[k] = float_r[k];
      end
    end
  end
endmodule

/* File: dv/bior_board_io_regs_tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// board io register bench
module bior_board_io_regs_tb_top;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [bior_pkg::ADDR_W-1:0] addr_i = 5'h00;
  logic [bior_pkg::DATA_W-1:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [bior_pkg::DATA_W-1:0] rdata_o;
  logic [3:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
  logic [3:0] ext_a = 4'h0, ext_b = 4'h0, ext_a_en = 4'h0, ext_b_en = 4'h0;
  logic [2:0] cnt_lvl = 3'h0, cnt_null = 3'h0;
  logic [55:0] sw;
  int failures = 0;
  int n_compared = 0;

  initial begin
    forever #50 clock_i = ~clock_i;
  end

  bior_board_io_regs dut_u (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .port_a_lines_i(pa_in), .port_a_lines_o(pa_out), .port_a_lines_oe_o(pa_oe),
    .port_b_lines_i(pb_in), .port_b_lines_o(pb_out), .port_b_lines_oe_o(pb_oe),
    .cnt_out_level_i(cnt_lvl), .cnt_null_count_i(cnt_null), .switch_ctrl_o(sw));
  bior_line_model model_a_u (.clock_i(clock_i), .dev_i(pa_out), .dev_oe_i(pa_oe),
    .ext_i(ext_a), .ext_en_i(ext_a_en), .lines_o(pa_in));
  bior_line_model model_b_u (.clock_i(clock_i), .dev_i(pb_out), .dev_oe_i(pb_oe),
    .ext_i(ext_b), .ext_en_i(ext_b_en), .lines_o(pb_in));

  // ==========================================================
  // report and compare
  task automatic finish_test();
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_route(input string what, input logic [55:0] exp, input logic [55:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ==========================================================
  // bus cycles; an idle edge after each so strobes are never reassigned at once
  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
    @(posedge clock_i);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_dio();
    logic [15:0] d;
    bus_wr(bior_pkg::OFS_CONFIG_REG_ONE, 16'h0000);
    ext_a <= 4'h3;
    ext_a_en <= 4'hF;
    ext_b <= 4'hC;
    ext_b_en <= 4'hF;
    bus_wr(bior_pkg::OFS_DIO, 16'hA5BA);
    chk_reg("stored patterns", 16'h00BA, {8'h00, pb_out, pa_out});
    chk_reg("drive enables", 16'h0000, {8'h00, pb_oe, pa_oe});
    repeat (2) @(posedge clock_i);
    bus_rd(bior_pkg::OFS_DIO, d);
    chk_reg("input lines", 16'h00C3, d);
    ext_a_en <= 4'h0;
    bus_wr(bior_pkg::OFS_CONFIG_REG_THREE, 16'h0001);
    chk_reg("drive enables a", 16'h000F, {8'h00, pb_oe, pa_oe});
    bus_rd(bior_pkg::OFS_CONFIG_REG_THREE, d);
    chk_reg("config three", 16'h0001, d);
    bus_wr(bior_pkg::OFS_DIO, 16'h5A37);
    repeat (2) @(posedge clock_i);
    bus_rd(bior_pkg::OFS_DIO, d);
    chk_reg("lines a driven", 16'h00C7, d);
    ext_b_en <= 4'h0;
    bus_wr(bior_pkg::OFS_CONFIG_REG_THREE, 16'h0002);
    ext_a_en <= 4'hF;
    chk_reg("drive enables b", 16'h00F0, {8'h00, pb_oe, pa_oe});
    repeat (2) @(posedge clock_i);
    bus_rd(bior_pkg::OFS_DIO, d);
    chk_reg("lines b driven", 16'h0033, d);
    bus_wr(bior_pkg::OFS_CONFIG_REG_ONE, 16'h0001);
    bus_rd(bior_pkg::OFS_DIO, d);
    chk_reg("input hidden by page", 16'h0000, d);
    bus_wr(bior_pkg::OFS_DIO, 16'h0055);
    chk_reg("output hidden by page", 16'h0037, {8'h00, pb_out, pa_out});
    bus_wr(bior_pkg::OFS_CONFIG_REG_ONE, 16'h0000);
    bus_wr(bior_pkg::OFS_CONFIG_REG_THREE, 16'h0000);
  endtask

  task automatic t_route();
    logic [55:0] pat;
    pat = 56'hC3A50F961E7BD2;
    bus_wr(bior_pkg::OFS_RT_SHIFT, 16'h0001);
    bus_wr(bior_pkg::OFS_RT_STROBE, 16'h0000);
    chk_route("routing with page clear", 56'h0, sw);
    bus_wr(bior_pkg::OFS_CONFIG_REG_ONE, 16'h0001);
    // first written bit ends at the top; data bits 7-1 carry the opposite value, bits 15-8 are all ones
    for (int i = 55; i >= 0; i--) begin
      bus_wr(bior_pkg::OFS_RT_SHIFT, {8'hFF, {7{~pat[i]}}, pat[i]});
    end
    chk_route("routing before strobe", 56'h0, sw);
    bus_wr(bior_pkg::OFS_RT_STROBE, 16'hFFFE);
    chk_route("routing after strobe", pat, sw);
    bus_wr(bior_pkg::OFS_CONFIG_REG_ONE, 16'h0000);
  endtask

  // reset in mid-run must drop the routing and release both ports
  task automatic t_reset();
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    chk_route("routing after reset", 56'h0, sw);
    chk_reg("ports after reset", 16'h0000, {pb_oe, pa_oe, pb_out, pa_out});
  endtask

  task automatic t_status();
    logic [15:0] d;
    cnt_lvl <= 3'b001;
    cnt_null <= 3'b010;
    bus_wr(bior_pkg::OFS_CNT_CMD, 16'h0034);
    bus_wr(bior_pkg::OFS_CNT_CMD, 16'h005B);
    bus_wr(bior_pkg::OFS_CNT_CMD, 16'h00E6);
    bus_rd(bior_pkg::OFS_CNT_STAT1, d);
    chk_reg("status one", 16'h00B4, d);
    bus_rd(bior_pkg::OFS_CNT_STAT2, d);
    chk_reg("status two", 16'h005B, d);
    // a latch command must not disturb the programmed access copy
    bus_wr(bior_pkg::OFS_CNT_CMD, 16'h0000);
    cnt_lvl <= 3'b110;
    cnt_null <= 3'b101;
    repeat (3) @(posedge clock_i);
    bus_wr(bior_pkg::OFS_CNT_CMD, 16'h00F2);
    bus_rd(bior_pkg::OFS_CNT_STAT1, d);
    chk_reg("status not requested", 16'h00B4, d);
    bus_wr(bior_pkg::OFS_CNT_CMD, 16'h00A9);
    bus_wr(bior_pkg::OFS_CNT_CMD, 16'h00EA);
    bus_rd(bior_pkg::OFS_CNT_STAT1, d);
    chk_reg("status one again", 16'h0074, d);
    bus_rd(bior_pkg::OFS_CNT_STAT3, d);
    chk_reg("status three", 16'h00E9, d);
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    t_dio();
    t_route();
    t_reset();
    t_status();
    finish_test();
  end
endmodule
